//--- mcb_pkg.sv
// Package: offsets, field positions and reset values of the hidden mode register
`default_nettype none

package mcb_pkg;

  // ---------------------------------------------------------------
  // Register location
  // ---------------------------------------------------------------
  localparam logic [1:0] PAGE_ZERO     = 2'h0;
  localparam logic [3:0] OFS_MODE_B    = 4'hb;

  // ---------------------------------------------------------------
  // Field positions of hidden_mode_config_b
  // ---------------------------------------------------------------
  localparam int B_MEDIA_LO            = 0;
  localparam int B_LINK                = 2;
  localparam int B_WIDE_IO             = 3;
  localparam int B_RDY_SRC             = 4;
  localparam int B_BUS_ERR             = 5;
  localparam int B_ROM_WR              = 6;
  localparam int B_RELOAD              = 7;

  // ---------------------------------------------------------------
  // Field positions of reset_loaded_config_c
  // ---------------------------------------------------------------
  localparam int C_WINDOW_LO           = 0;
  localparam int C_IRQ_STYLE           = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_MEDIA     = 2'h0;
  localparam logic       RST_LINK_OFF  = 1'b0;
  localparam logic       RST_WIDE_IO   = 1'b0;
  localparam logic       RST_RDY_SRC   = 1'b0;
  localparam logic       RST_ROM_WR    = 1'b0;
  localparam logic [7:0] RST_CFG_C     = 8'h00;

  // ---------------------------------------------------------------
  // Media codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MEDIA_TP_STD  = 2'h0;
  localparam logic [1:0] MEDIA_THICK   = 2'h1;
  localparam logic [1:0] MEDIA_THIN    = 2'h2;
  localparam logic [1:0] MEDIA_TP_LOW  = 2'h3;

  // ---------------------------------------------------------------
  // Boot window decode (16 KB slots from segment c000)
  // ---------------------------------------------------------------
  localparam logic [5:0] ROM_SLOT_BASE = 6'h30;
  localparam logic [3:0] ROM_CODE_BASE = 4'h2;

endpackage : mcb_pkg

`default_nettype wire

//--- mcb_cfg_if.sv
// Interface between the mode register and the media control block
`default_nettype none

interface mcb_cfg_if;
  logic [1:0] media_select;
  logic       link_test_off;
  logic       link_state_field;

  // Register side drives the settings and reads link state back
  modport regs (output media_select, output link_test_off, input link_state_field);
  // Media side decodes settings and reports link state
  modport phy  (input media_select, input link_test_off, output link_state_field);
endinterface : mcb_cfg_if

`default_nettype wire

//--- mcb_phy_ctl.sv
// Media select decode and link state reporting
`default_nettype none

module mcb_phy_ctl (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  mcb_cfg_if.phy    cfg,
  input  wire logic link_good_i,
  output logic      tp_enable_o,
  output logic      aui_enable_o,
  output logic      low_squelch_o,
  output logic      coax_thin_o,
  output logic      link_led_o
);

  typedef struct packed {
    logic tp;
    logic aui;
    logic low_sq;
    logic thin;
    logic link;
  } mcb_phy_st_t;

  mcb_phy_st_t st_reg;
  mcb_phy_st_t st_next;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Two twisted pair codes, two AUI codes
  always_comb
  begin
    st_next        = st_reg;
    st_next.tp     = (cfg.media_select == mcb_pkg::MEDIA_TP_STD) ||
                     (cfg.media_select == mcb_pkg::MEDIA_TP_LOW);      // [R4]
    st_next.aui    = !st_next.tp;                                     // [R4] [R7]
    st_next.low_sq = (cfg.media_select == mcb_pkg::MEDIA_TP_LOW);     // [R5] [R6]
    st_next.thin   = (cfg.media_select == mcb_pkg::MEDIA_THIN);       // [R8]
    // AUI always reports no link; disabled test forces good
    st_next.link   = st_next.tp && (cfg.link_test_off || link_good_i); // [R10] [R11]
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tp_enable_o           = st_reg.tp;
  assign aui_enable_o          = st_reg.aui;
  assign low_squelch_o         = st_reg.low_sq;
  assign coax_thin_o           = st_reg.thin;
  assign link_led_o            = st_reg.link;   // Same value the register reads [R11]
  assign cfg.link_state_field  = st_reg.link;

endmodule : mcb_phy_ctl

`default_nettype wire

//--- mcb_mode_regs.sv
// Hidden mode register B, reset-loaded register C and their bus-side effects
//
// How it works
// [R1] Page 0 offset 0b reads back register B instead of a reserved value.
// [R2] A write to 0b updates B only right after a read of 0b.
// [R3] Any access between read and write diverts the write to remote count high.
// [R4] Two-bit media field picks two twisted pair and two AUI interfaces.
// [R5] Media code 00 is twisted pair with standard squelch level.
// [R6] Media code 11 is twisted pair with lowered receive squelch.
// [R7] Codes 01 and 10 are thick and thin coax through AUI.
// [R8] Coax-mode pin is low for thick coax, high for thin coax.
// [R9] Writing 1 to link bit 2 stops link pulses and integrity checks.
// [R10] Link bit reads 0 in AUI mode or with testing on and link bad.
// [R11] Link bit reads 1 in twisted pair mode with good link or testing off; matches LED.
// [R12] Wide-IO select 1 waits for a command strobe; 0 uses decode only.
// [R13] Ready timing select 0 starts after command strobe, 1 after BALE.
// [R14] Bus error sets when host ends a cycle while waits were wanted.
// [R15] Writing 1 clears bus error; writing 0 leaves it.
// [R16] Software should not read-modify-write register B.
// [R17] Boot PROM write bit low blocks all boot PROM write cycles.
// [R18] Writing 1 to bit 7 starts the EEPROM configuration load.
// [R19] Boards should never preset the EEPROM load bit high.
// [R20] Register C loads only in reset and is invisible to software; here it takes the straps on the first edge after reset release.
// [R21] Register C bit 5 picks direct or coded interrupt output.
// [R22] Register C bits 0-3 place the boot PROM window; reads there return PROM data.
`default_nettype none

module mcb_mode_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // Host register port, one pulse per access
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [1:0]  reg_page_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rhit_o,
  output logic             rcount_hi_wr_o,
  output logic [7:0]       rcount_hi_data_o,
  // ISA timing
  input  wire logic        addr_decode_i,
  input  wire logic        cmd_active_i,
  input  wire logic        bale_i,
  input  wire logic        wait_wanted_i,
  input  wire logic        cycle_end_i,
  output logic             io16_o,
  output logic             ready_start_o,
  // Boot PROM and EEPROM
  input  wire logic        prom_wr_req_i,
  output logic             prom_wr_o,
  input  wire logic [19:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        shared_mem_i,
  output logic             prom_rd_sel_o,
  output logic             rom_reload_start_o,
  input  wire logic        rom_reload_done_i,
  // Straps and interrupt style
  input  wire logic [7:0]  strap_c_i,
  output logic             irq_style_sel_o,
  // Media
  input  wire logic        link_good_i,
  output logic             tp_enable_o,
  output logic             aui_enable_o,
  output logic             low_squelch_o,
  output logic             coax_thin_o,
  output logic             link_led_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       armed;
    logic [1:0] media_select;
    logic       link_state_ctl;
    logic       wide_io_timing_sel;
    logic       rdy_src_sel;
    logic       bus_error_flag;
    logic       boot_rom_write_allow;
    logic       rom_reload_trigger;
    logic       c_loaded;
    logic [7:0] cfg_c;
    logic [7:0] rdata;
    logic       rhit;
    logic       rc_wr;
    logic [7:0] rc_data;
    logic       reload_go;
    logic       io16;
    logic       rdy_go;
    logic       prom_wr;
    logic       prom_rd;
  } mcb_regs_st_t;

  mcb_regs_st_t st_reg;
  mcb_regs_st_t st_next;

  logic hit_b;
  logic any_acc;
  logic link_state_field;

  mcb_cfg_if cfg_bus ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Address falls in the boot window chosen by the register C code
  function automatic logic rom_hit(input logic [3:0]  code,
                                   input logic [19:0] addr,
                                   input logic        big);
    logic [3:0] slot;
    logic       ok;
    slot = code - mcb_pkg::ROM_CODE_BASE;
    ok   = (code[3:1] != 3'h0);
    ok   = ok && (addr[19:14] == (mcb_pkg::ROM_SLOT_BASE + {2'h0, slot}));
    // 8 KB windows only use the lower half of the slot
    ok   = ok && (big || !addr[13]);
    return ok;
  endfunction

  // Value software sees when reading register B
  function automatic logic [7:0] pack_b(input mcb_regs_st_t s,
                                        input logic         lnk);
    logic [7:0] v;
    v                                   = 8'h00;
    v[mcb_pkg::B_MEDIA_LO +: 2]         = s.media_select;
    v[mcb_pkg::B_LINK]                  = lnk;
    v[mcb_pkg::B_WIDE_IO]               = s.wide_io_timing_sel;
    v[mcb_pkg::B_RDY_SRC]               = s.rdy_src_sel;
    v[mcb_pkg::B_BUS_ERR]               = s.bus_error_flag;
    v[mcb_pkg::B_ROM_WR]                = s.boot_rom_write_allow;
    v[mcb_pkg::B_RELOAD]                = s.rom_reload_trigger;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  assign hit_b   = (reg_page_i == mcb_pkg::PAGE_ZERO) &&
                   (reg_addr_i == mcb_pkg::OFS_MODE_B);
  assign any_acc = reg_rd_i || reg_wr_i;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    st_next.rhit      = 1'b0;
    st_next.rc_wr     = 1'b0;
    st_next.reload_go = 1'b0;

    // Straps captured on the first edge after release, then frozen
    if (!st_reg.c_loaded)
    begin
      st_next.cfg_c    = strap_c_i;                    // [R20]
      st_next.c_loaded = 1'b1;
    end

    // Read of 0b returns B and arms the write unlock
    if (reg_rd_i && hit_b)
    begin
      st_next.rdata = pack_b(st_reg, link_state_field);  // [R1] [R10] [R11]
      st_next.rhit  = 1'b1;                              // [R1]
    end

    // Any other access breaks the read-then-write pair
    if (any_acc)
      st_next.armed = reg_rd_i && hit_b;                 // [R2] [R3]

    // Hardware set of bus error; the clear below is gated off in that cycle so set wins
    if (wait_wanted_i && cycle_end_i)
      st_next.bus_error_flag = 1'b1;                     // [R14]

    if (reg_wr_i && hit_b)
    begin
      if (st_reg.armed)
      begin
        st_next.media_select         = reg_wdata_i[mcb_pkg::B_MEDIA_LO +: 2]; // [R2] [R4]
        st_next.link_state_ctl       = reg_wdata_i[mcb_pkg::B_LINK];          // [R9]
        st_next.wide_io_timing_sel   = reg_wdata_i[mcb_pkg::B_WIDE_IO];
        st_next.rdy_src_sel          = reg_wdata_i[mcb_pkg::B_RDY_SRC];
        st_next.boot_rom_write_allow = reg_wdata_i[mcb_pkg::B_ROM_WR];
        // Write one to clear, unless a new error lands this cycle
        if (reg_wdata_i[mcb_pkg::B_BUS_ERR] && !(wait_wanted_i && cycle_end_i))
          st_next.bus_error_flag = 1'b0;                 // [R15]
        // A reload already running is not restarted
        if (reg_wdata_i[mcb_pkg::B_RELOAD] && !st_reg.rom_reload_trigger)
        begin
          st_next.rom_reload_trigger = 1'b1;             // [R18]
          st_next.reload_go          = 1'b1;             // [R18]
        end
      end
      else
      begin
        st_next.rc_wr   = 1'b1;                          // [R3]
        st_next.rc_data = reg_wdata_i;                   // [R3]
      end
    end

    // Load engine reports completion; bit reads 1 only while loading
    if (rom_reload_done_i && !st_next.reload_go)
      st_next.rom_reload_trigger = 1'b0;

    // Wide-IO: with decode alone, or only once a strobe is active
    st_next.io16 = st_reg.wide_io_timing_sel ? (addr_decode_i && cmd_active_i)
                                             : addr_decode_i;                   // [R12]
    // Ready timing follows either the strobe or BALE
    st_next.rdy_go = st_reg.rdy_src_sel ? bale_i : cmd_active_i;                // [R13]

    // PROM writes blocked unless enabled
    st_next.prom_wr = prom_wr_req_i && st_reg.boot_rom_write_allow;             // [R17]
    st_next.prom_rd = mem_rd_i &&
                      rom_hit(st_reg.cfg_c[mcb_pkg::C_WINDOW_LO +: 4],
                              mem_addr_i, shared_mem_i);                        // [R22]
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset constants only; straps are taken after release
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg                      <= '0;
      st_reg.media_select         <= mcb_pkg::RST_MEDIA;
      st_reg.link_state_ctl       <= mcb_pkg::RST_LINK_OFF;
      st_reg.wide_io_timing_sel   <= mcb_pkg::RST_WIDE_IO;
      st_reg.rdy_src_sel          <= mcb_pkg::RST_RDY_SRC;
      st_reg.boot_rom_write_allow <= mcb_pkg::RST_ROM_WR;
      st_reg.cfg_c                <= mcb_pkg::RST_CFG_C;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Media and link block
  // ---------------------------------------------------------------
  assign cfg_bus.media_select  = st_reg.media_select;
  assign cfg_bus.link_test_off = st_reg.link_state_ctl;   // [R9]
  assign link_state_field      = cfg_bus.link_state_field;

  mcb_phy_ctl u_phy (
    .sys_clk_i     (sys_clk_i),
    .nrst_i        (nrst_i),
    .cfg           (cfg_bus),
    .link_good_i   (link_good_i),
    .tp_enable_o   (tp_enable_o),
    .aui_enable_o  (aui_enable_o),
    .low_squelch_o (low_squelch_o),
    .coax_thin_o   (coax_thin_o),
    .link_led_o    (link_led_o)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o        = st_reg.rdata;
  assign reg_rhit_o         = st_reg.rhit;
  assign rcount_hi_wr_o     = st_reg.rc_wr;
  assign rcount_hi_data_o   = st_reg.rc_data;
  assign io16_o             = st_reg.io16;
  assign ready_start_o      = st_reg.rdy_go;
  assign prom_wr_o          = st_reg.prom_wr;
  assign prom_rd_sel_o      = st_reg.prom_rd;
  assign rom_reload_start_o = st_reg.reload_go;
  assign irq_style_sel_o    = st_reg.cfg_c[mcb_pkg::C_IRQ_STYLE];  // [R21]

endmodule : mcb_mode_regs

`default_nettype wire

//--- mcb_mode_regs_asserts.sv
// Checker: concurrent assertions on the hidden mode register ports
`default_nettype none

module mcb_mode_regs_asserts (
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic       reg_rd_i,
  input wire logic       reg_wr_i,
  input wire logic [1:0] reg_page_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rhit_o,
  input wire logic       rcount_hi_wr_o,
  input wire logic [7:0] rcount_hi_data_o,
  input wire logic       addr_decode_i,
  input wire logic       cmd_active_i,
  input wire logic       bale_i,
  input wire logic       io16_o,
  input wire logic       ready_start_o,
  input wire logic       prom_wr_o,
  input wire logic       rom_reload_start_o,
  input wire logic       rom_reload_done_i,
  input wire logic       tp_enable_o,
  input wire logic       aui_enable_o,
  input wire logic       low_squelch_o,
  input wire logic       coax_thin_o,
  input wire logic       link_led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Mirror of register B from paired writes
  // ----------------------------------------
  logic       armed_reg;
  logic       busy_reg;
  logic [6:0] mir_reg;
  logic [1:0] age_reg;
  wire logic  hit_b = reg_page_i == mcb_pkg::PAGE_ZERO && reg_addr_i == mcb_pkg::OFS_MODE_B;
  wire logic  arm_wr = reg_wr_i && hit_b && armed_reg;
  // Outputs lag the register by up to two stages, so wait three
  wire logic  calm = age_reg == 2'h3 && !arm_wr;
  wire logic  tp = mir_reg[1] == mir_reg[0];

  // Track arming, settled age and reload busy
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      armed_reg <= 1'b0;
      busy_reg  <= 1'b0;
      mir_reg   <= 7'h00;
      age_reg   <= 2'h0;
    end
    else
    begin
      if (reg_rd_i || reg_wr_i)
        armed_reg <= reg_rd_i && hit_b;
      if (rom_reload_start_o || rom_reload_done_i)
        busy_reg <= rom_reload_start_o;
      if (arm_wr)
        mir_reg <= reg_wdata_i[6:0];
      age_reg <= arm_wr ? 2'h0 : (age_reg == 2'h3 ? age_reg : age_reg + 2'h1);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_read_answer: assert property (reg_rd_i && hit_b |=> reg_rhit_o)
    else $error("mode register read not answered");
  a_pair_write: assert property (arm_wr |=> !rcount_hi_wr_o)
    else $error("paired write was diverted");
  a_divert_write: assert property (reg_wr_i && hit_b && !armed_reg |=>
    rcount_hi_wr_o && rcount_hi_data_o == $past(reg_wdata_i))
    else $error("unpaired write not diverted");
  a_media_decode: assert property (calm |-> tp_enable_o == tp
    && aui_enable_o == !tp && low_squelch_o == (mir_reg[1:0] == mcb_pkg::MEDIA_TP_LOW))
    else $error("media decode wrong");
  a_coax_level: assert property (calm && !tp |-> coax_thin_o == mir_reg[1])
    else $error("coax pin level wrong");
  a_link_aui: assert property (calm && !tp |-> !link_led_o)
    else $error("link shown in coax mode");
  a_link_off: assert property (calm && tp && mir_reg[2] |-> link_led_o)
    else $error("link not shown with testing off");
  a_wide_decode: assert property (calm && !mir_reg[3] |=> io16_o == $past(addr_decode_i))
    else $error("io16 not from decode");
  a_ready_src: assert property (calm |=>
    ready_start_o == (mir_reg[4] ? $past(bale_i) : $past(cmd_active_i)))
    else $error("ready start source wrong");
  a_rom_gate: assert property (calm && !mir_reg[6] |=> !prom_wr_o)
    else $error("boot rom write not blocked");
  a_reload_go: assert property (arm_wr && reg_wdata_i[7] && !busy_reg &&
    !rom_reload_start_o |=> rom_reload_start_o)
    else $error("reload not started");
endmodule : mcb_mode_regs_asserts

bind mcb_mode_regs mcb_mode_regs_asserts u_asserts (.sys_clk_i, .nrst_i, .reg_rd_i,
  .reg_wr_i, .reg_page_i, .reg_addr_i, .reg_wdata_i, .reg_rhit_o, .rcount_hi_wr_o,
  .rcount_hi_data_o, .addr_decode_i, .cmd_active_i, .bale_i, .io16_o, .ready_start_o,
  .prom_wr_o, .rom_reload_start_o, .rom_reload_done_i, .tp_enable_o, .aui_enable_o,
  .low_squelch_o, .coax_thin_o, .link_led_o);

`default_nettype wire

//--- mcb_eeprom_model.sv
// Partner model: configuration loader answering a reload start
`default_nettype none

module mcb_eeprom_model #(
  parameter int LOAD_CYCLES = 40
) (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output var logic  done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Load takes a while, then one done pulse; a real loader is never instant
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt    <= 0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= cnt == 1;
      cnt    <= start_i ? LOAD_CYCLES : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule : mcb_eeprom_model

`default_nettype wire

//--- mcb_mode_regs_tb_top.sv
// Testbench: host accesses to the hidden mode register
`default_nettype none

module mcb_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, nrst_i, reg_rd_i, reg_wr_i, reg_rhit_o, rcount_hi_wr_o;
  logic addr_decode_i, cmd_active_i, bale_i, wait_wanted_i, cycle_end_i, io16_o;
  logic ready_start_o, prom_wr_req_i, prom_wr_o, mem_rd_i, shared_mem_i, prom_rd_sel_o;
  logic rom_reload_start_o, rom_reload_done_i, irq_style_sel_o, link_good_i;
  logic tp_enable_o, aui_enable_o, low_squelch_o, coax_thin_o, link_led_o;
  logic [1:0]  reg_page_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, rcount_hi_data_o, strap_c_i;
  logic [19:0] mem_addr_i;
  int          errors, cmp_count;

  mcb_mode_regs DUT (.sys_clk_i, .nrst_i, .reg_rd_i, .reg_wr_i, .reg_page_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rhit_o, .rcount_hi_wr_o, .rcount_hi_data_o,
    .addr_decode_i, .cmd_active_i, .bale_i, .wait_wanted_i, .cycle_end_i, .io16_o,
    .ready_start_o, .prom_wr_req_i, .prom_wr_o, .mem_addr_i, .mem_rd_i, .shared_mem_i,
    .prom_rd_sel_o, .rom_reload_start_o, .rom_reload_done_i, .strap_c_i, .irq_style_sel_o,
    .link_good_i, .tp_enable_o, .aui_enable_o, .low_squelch_o, .coax_thin_o, .link_led_o);
  mcb_eeprom_model u_loader (.sys_clk_i, .nrst_i, .start_i(rom_reload_start_o),
    .done_o(rom_reload_done_i));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Inputs always change 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    q = reg_rdata_o;
    check("read hit", reg_rhit_o, a == 4'hb);
    tick(1); // Idle edge, so a following read never re-raises the strobe at once
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic div);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    check("diverted write", rcount_hi_wr_o, div);
    if (div)
      check("diverted data", rcount_hi_data_o, d);
  endtask

  // Paired read then write, then let the outputs settle
  task automatic setb(input logic [7:0] d);
    logic [7:0] q;
    rd(4'hb, q);
    wr(4'hb, d, 1'b0);
    tick(3);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Whole run is near 200 cycles; give it ample room
  initial
  begin
    #100us;
    errors++;
    end_of_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] q;
    errors = 0;
    cmp_count = 0;
    {reg_rd_i, reg_wr_i, reg_page_i, reg_addr_i, reg_wdata_i} = 16'h0000;
    {addr_decode_i, cmd_active_i, bale_i, wait_wanted_i, cycle_end_i} = 5'h00;
    {prom_wr_req_i, mem_rd_i, mem_addr_i} = 22'h000000;
    {shared_mem_i, link_good_i} = 2'h3;
    strap_c_i = 8'h22; // Straps: boot window code 2, interrupt style bit 5 high
    nrst_i = 1'b0;
    tick(20);
    nrst_i = 1'b1;
    tick(2);
    strap_c_i = 8'h00; // Late strap change must not reach register C
    rd(4'hb, q);
    check("reset value", q, 8'h04);
    check("irq style", irq_style_sel_o, 1'b1);
    mem_rd_i = 1'b1;
    mem_addr_i = 20'hc0010;
    tick(2);
    check("boot window hit", prom_rd_sel_o, 1'b1);
    mem_addr_i = 20'hc4010;
    tick(2);
    check("boot window miss", prom_rd_sel_o, 1'b0);
    shared_mem_i = 1'b0;
    mem_addr_i = 20'hc2010;
    tick(2);
    check("small window miss", prom_rd_sel_o, 1'b0);
    mem_rd_i = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      setb(8'(m));
      rd(4'hb, q);
      check("media and link", q, {5'h00, m == 0 || m == 3, 2'(m)});
      check("twisted pair", tp_enable_o, m == 0 || m == 3);
      check("aui select", aui_enable_o, m == 1 || m == 2);
      check("low squelch", low_squelch_o, m == 3);
      if (m == 1 || m == 2)
        check("coax pin", coax_thin_o, m == 2);
    end
    link_good_i = 1'b0;
    setb(8'h04);
    check("link forced", link_led_o, 1'b1);
    setb(8'h00);
    rd(4'hb, q);
    check("link bad", q, 8'h00);
    link_good_i = 1'b1;
    rd(4'h3, q);
    wr(4'hb, 8'h5a, 1'b1);
    rd(4'hb, q);
    rd(4'h3, q);
    wr(4'hb, 8'h5b, 1'b1);
    tick(3);
    rd(4'hb, q);
    check("unchanged after divert", q, 8'h04);
    {wait_wanted_i, cycle_end_i} = 2'h3;
    tick(1);
    {wait_wanted_i, cycle_end_i} = 2'h0;
    tick(1);
    rd(4'hb, q);
    check("bus error set", q[5], 1'b1);
    wr(4'hb, 8'h00, 1'b0);
    tick(1);
    rd(4'hb, q);
    check("bus error kept", q[5], 1'b1);
    wr(4'hb, 8'h20, 1'b0);
    tick(1);
    rd(4'hb, q);
    check("bus error cleared", q[5], 1'b0);
    prom_wr_req_i = 1'b1;
    tick(2);
    check("rom write blocked", prom_wr_o, 1'b0);
    setb(8'h40);
    check("rom write passed", prom_wr_o, 1'b1);
    prom_wr_req_i = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      setb(s ? 8'h18 : 8'h00);
      for (int i = 0; i < 8; i++)
      begin
        {addr_decode_i, cmd_active_i, bale_i} = 3'(i);
        tick(2);
        check("ready start", ready_start_o, s ? bale_i : cmd_active_i);
        check("io16", io16_o, addr_decode_i && (s == 0 || cmd_active_i));
      end
    end
    rd(4'hb, q);
    wr(4'hb, 8'h80, 1'b0);
    check("reload start", rom_reload_start_o, 1'b1);
    rd(4'hb, q);
    check("reload busy", q[7], 1'b1);
    for (int i = 0; i < 100 && !rom_reload_done_i; i++)
      tick(1);
    tick(2);
    rd(4'hb, q);
    check("reload done", q[7], 1'b0);
    end_of_test();
  end
endmodule : mcb_mode_regs_tb_top

`default_nettype wire
